// ==== rtl/mra_pkg.sv ====
`default_nettype none
package mra_pkg;
// Behaviour
// - each PHY port holds 32 standard registers; 0h-Fh IEEE, 10h-1Fh vendor-specific.
// - register r of port N lives in bytes 0xN100 plus 2r and the next.
// - registers Dh and Eh form the setup/data pair for indirect extended registers.
// - in-band engine reads and writes every register through the selected data port.
// - in-band port selection is port 6 after reset until changed.
// - in-band access is enabled by a strap caught at reset release.
// - only one in-band port; it still carries normal traffic.
// - management frames skip lookup, tagging, filtering and discard checks.
// - management frames are consumed, never forwarded to fabric or ports.
// - response swaps destination and source MAC addresses.
// - 4-byte tag follows source address, then management EtherType.
// - one frame at a time; later frames dropped until response fully sent.
// - commands are read, write, wait-zero, wait-one, clear-masked, set-masked.
// - every in-band transfer moves 32 bits; no byte or halfword option.
// - read and write bursts move consecutive words bounded by frame buffer.
// - station management PHY addresses 1h-5h select ports 1-5.
  localparam logic [15:0] PHY_BASE = 16'h0100;
  localparam logic [31:0] RSV_MAP = 32'h67d1_1800;
  localparam logic [4:0] PHY_FIRST = 5'h01;
  localparam logic [4:0] PHY_LAST = 5'h05;
  localparam logic [2:0] IB_DEFAULT_PORT = 3'h6;
  localparam logic [2:0] PORT_FIRST = 3'h1;
  localparam logic [2:0] PORT_LAST = 3'h6;
  // arbitrary values
  localparam logic [47:0] SWITCH_MAC = 48'h02_00_00_00_00_01;
  localparam logic [15:0] MGMT_ETYPE = 16'h88b5;
  localparam int BUF_DEPTH = 128;
  localparam logic [7:0] BUF_LEN = 8'h80;
  localparam logic [7:0] MAC_LEN = 8'h06;
  localparam logic [7:0] ETYPE_POS = 8'h10;
  localparam logic [7:0] HDR_LEN = 8'h12;
  localparam logic [7:0] CMD_LEN = 8'h04;
  localparam logic [7:0] WORD_LEN = 8'h04;
  localparam logic [7:0] POLL_LIMIT = 8'hff;
  localparam logic [1:0] LAST_WORD_BYTE = 2'h3;
  localparam logic [1:0] LAST_HALF_BYTE = 2'h1;
  localparam int FIFO_DEPTH = 4;
  typedef enum logic [2:0] {
    OP_END = 3'b000, OP_READ = 3'b001, OP_WRITE = 3'b010, OP_WAIT0 = 3'b011,
    OP_WAIT1 = 3'b100, OP_CLR = 3'b101, OP_SET = 3'b110
  } mra_op_type;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_CMD = 4'b0001, S_WORD = 4'b0010, S_ACC = 4'b0011,
    S_POST = 4'b0100, S_MODW = 4'b0101, S_SMI_END = 4'b0110, S_TX = 4'b0111,
    S_DRAIN = 4'b1000
  } mra_state_type;

  function automatic mra_op_type to_op(input logic [7:0] b);
    to_op = (b[2:0] inside {[3'h1:3'h6]}) ? mra_op_type'(b[2:0]) : OP_END;
  endfunction : to_op

  function automatic logic [15:0] phy_addr(input logic [4:0] phy, input logic [4:0] r);
    phy_addr = {phy[3:0], 12'h000} | PHY_BASE | {10'h000, r, 1'h0};
  endfunction : phy_addr

  function automatic logic [7:0] swap_idx(input logic [7:0] i);
    if (i < MAC_LEN) swap_idx = i + MAC_LEN;
    else if (i < 8'(MAC_LEN + MAC_LEN)) swap_idx = i - MAC_LEN;
    else swap_idx = i;
  endfunction : swap_idx

  function automatic logic byte_ok(input logic [7:0] pos, input logic [7:0] b);
    logic [5:0] sft;
    sft = 6'((MAC_LEN - 8'h01 - pos) << 3);
    if (pos < MAC_LEN) byte_ok = (b == 8'(SWITCH_MAC >> sft));
    else if (pos == ETYPE_POS) byte_ok = (b == MGMT_ETYPE[15:8]);
    else if (pos == 8'(ETYPE_POS + 8'h01)) byte_ok = (b == MGMT_ETYPE[7:0]);
    else byte_ok = 1'h1;
  endfunction : byte_ok
endpackage : mra_pkg
`default_nettype wire

// ==== rtl/mra_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module mra_fifo #(
  parameter int W = 9,
  parameter int D = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr;
  logic [AW-1:0] rd;
  logic [AW:0] cnt;
  logic push;
  logic pop;

  assign in_ready = (cnt != (AW+1)'(D));
  assign out_valid = (cnt != '0);
  assign out_data = mem[rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) mem[wr] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr <= '0;
      rd <= '0;
      cnt <= '0;
    end else begin
      if (push) wr <= (wr == AW'(D - 1)) ? '0 : wr + AW'(1);
      if (pop) rd <= (rd == AW'(D - 1)) ? '0 : rd + AW'(1);
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : mra_fifo

module mra_top
  import mra_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration
  input wire logic in_band_access_strap,
  input wire logic ib_sel_wr,
  input wire logic [2:0] ib_sel_port,
  output logic ib_en,
  output logic [2:0] ib_port,
  // receive stream from all ports
  input wire logic rx_valid,
  input wire logic [2:0] rx_port,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  // frame verdict to switch fabric
  output logic vd_valid,
  output logic vd_mgmt,
  output logic vd_drop,
  // response stream
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [2:0] tx_port,
  output logic [7:0] tx_data,
  output logic tx_last,
  // station_mgmt_serial request
  input wire logic smi_req,
  input wire logic smi_write,
  input wire logic [4:0] smi_phy,
  input wire logic [4:0] smi_reg,
  input wire logic [15:0] smi_wdata,
  output logic smi_ack,
  output logic [15:0] smi_rdata,
  // internal byte register bus
  output logic rb_req,
  output logic rb_we,
  output logic [15:0] rb_addr,
  output logic [7:0] rb_wdata,
  input wire logic rb_ack,
  input wire logic [7:0] rb_rdata
);
  logic strap_done;
  logic sel_touched;
  logic [7:0] fbuf [BUF_DEPTH];
  logic [7:0] rx_cnt;
  logic [7:0] flen;
  logic [2:0] resp_port;
  logic in_frame;
  logic hit;
  logic cap_on;
  logic ib_busy;
  logic first;
  logic cap_n;
  logic hit_n;
  logic mgmt_end;
  mra_state_type st;
  mra_state_type ret;
  mra_op_type op;
  logic [15:0] addr;
  logic [7:0] cnt;
  logic [7:0] ptr;
  logic [7:0] polls;
  logic [1:0] acc_k;
  logic [1:0] acc_last;
  logic acc_we;
  logic acc_wait;
  logic acc_smi;
  logic [31:0] acc_word;
  logic [31:0] buf_word;
  logic [7:0] tx_idx;
  logic smi_rsv_n;
  logic smi_go;
  logic [15:0] smi_map;
  logic f_in_valid;
  logic f_in_ready;
  logic [8:0] f_in_data;
  logic f_out_valid;
  logic f_out_ready;
  logic [8:0] f_out_data;
  logic tx_done;

  // strap and port selection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ib_en <= 1'h0;
      strap_done <= 1'h0;
      ib_port <= IB_DEFAULT_PORT;
      sel_touched <= 1'h0;
    end else begin
      if (!strap_done) begin
        ib_en <= in_band_access_strap;
        strap_done <= 1'h1;
      end
      if (ib_sel_wr && ib_sel_port >= PORT_FIRST && ib_sel_port <= PORT_LAST) begin
        ib_port <= ib_sel_port;
        sel_touched <= 1'h1;
      end
    end
  end

  // frame classification on the selected port only
  always_comb begin
    first = !in_frame;
    cap_n = first ? !ib_busy : cap_on;
    hit_n = (first ? (ib_en && rx_port == ib_port) : hit)
            && byte_ok(rx_cnt, rx_data);
    mgmt_end = hit_n && rx_cnt >= 8'(HDR_LEN - 8'h01);
  end

  assign tx_done = tx_valid && tx_ready && tx_last;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_frame <= 1'h0;
      hit <= 1'h0;
      cap_on <= 1'h0;
      rx_cnt <= '0;
      vd_valid <= 1'h0;
      vd_mgmt <= 1'h0;
      vd_drop <= 1'h0;
      flen <= '0;
      resp_port <= '0;
      ib_busy <= 1'h0;
    end else begin
      vd_valid <= 1'h0;
      if (tx_done) ib_busy <= 1'h0;
      if (rx_valid) begin
        in_frame <= !rx_last;
        hit <= hit_n;
        cap_on <= cap_n;
        if (rx_cnt != 8'hff) rx_cnt <= rx_cnt + 8'h01;
        if (rx_last) begin
          rx_cnt <= '0;
          vd_valid <= 1'h1;
          // fabric bypasses lookup and filtering, never forwards
          vd_mgmt <= mgmt_end;
          vd_drop <= mgmt_end && !cap_n;
          if (mgmt_end && cap_n) begin
            ib_busy <= 1'h1;
            flen <= (rx_cnt < BUF_LEN) ? rx_cnt + 8'h01 : BUF_LEN;
            resp_port <= rx_port;
          end
        end
      end
    end
  end

  always_comb begin
    buf_word = {fbuf[7'(ptr)], fbuf[7'(ptr + 8'h01)], fbuf[7'(ptr + 8'h02)],
                fbuf[7'(ptr + 8'h03)]};
  end

  // frame buffer: capture, then read results written in place
  always_ff @(posedge clk) begin
    if (rx_valid && cap_n && rx_cnt < BUF_LEN) fbuf[7'(rx_cnt)] <= rx_data;
    if (st == S_POST && op == OP_READ) begin
      fbuf[7'(ptr)] <= acc_word[31:24];
      fbuf[7'(ptr + 8'h01)] <= acc_word[23:16];
      fbuf[7'(ptr + 8'h02)] <= acc_word[15:8];
      fbuf[7'(ptr + 8'h03)] <= acc_word[7:0];
    end
  end

  assign smi_rsv_n = RSV_MAP[smi_reg] || smi_phy < PHY_FIRST || smi_phy > PHY_LAST;
  assign smi_go = (st == S_IDLE) && !ib_busy && smi_req;
  assign smi_map = phy_addr(smi_phy, smi_reg);

  // access engine shared by frames and station management
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= S_IDLE;
      ret <= S_IDLE;
      op <= OP_END;
      addr <= '0;
      cnt <= '0;
      ptr <= '0;
      polls <= '0;
      acc_k <= '0;
      acc_last <= '0;
      acc_we <= 1'h0;
      acc_wait <= 1'h0;
      acc_smi <= 1'h0;
      acc_word <= '0;
      rb_req <= 1'h0;
      rb_we <= 1'h0;
      rb_addr <= '0;
      rb_wdata <= '0;
      smi_ack <= 1'h0;
      smi_rdata <= '0;
      tx_idx <= '0;
    end else begin
      rb_req <= 1'h0;
      smi_ack <= 1'h0;
      unique case (st)
        S_IDLE: begin
          if (ib_busy) begin
            ptr <= HDR_LEN;
            acc_smi <= 1'h0;
            st <= S_CMD;
          end else if (smi_req && smi_rsv_n) begin
            smi_ack <= 1'h1;
            smi_rdata <= '0;
          end else if (smi_req) begin
            acc_smi <= 1'h1;
            addr <= smi_map;
            acc_k <= '0;
            acc_last <= LAST_HALF_BYTE;
            acc_we <= smi_write;
            acc_word <= {smi_wdata, 16'h0000};
            ret <= S_SMI_END;
            st <= S_ACC;
          end
        end
        S_ACC: begin
          // bytes go high first; word rotates so reads land big-endian
          if (!acc_wait) begin
            rb_req <= 1'h1;
            rb_we <= acc_we;
            rb_addr <= addr + {14'h0000, acc_k};
            rb_wdata <= acc_word[31:24];
            acc_wait <= 1'h1;
          end else if (rb_ack) begin
            acc_wait <= 1'h0;
            acc_word <= {acc_word[23:0], acc_we ? acc_word[31:24] : rb_rdata};
            if (acc_k == acc_last) st <= ret;
            else acc_k <= acc_k + 2'h1;
          end
        end
        S_SMI_END: begin
          smi_ack <= 1'h1;
          smi_rdata <= acc_word[15:0];
          st <= S_IDLE;
        end
        S_CMD: begin
          if (8'(ptr + CMD_LEN) > flen || to_op(fbuf[7'(ptr)]) == OP_END) begin
            tx_idx <= '0;
            st <= S_TX;
          end else begin
            op <= to_op(fbuf[7'(ptr)]);
            addr <= {fbuf[7'(ptr + 8'h01)], fbuf[7'(ptr + 8'h02)]};
            cnt <= fbuf[7'(ptr + 8'h03)];
            ptr <= ptr + CMD_LEN;
            polls <= '0;
            st <= S_WORD;
          end
        end
        S_WORD: begin
          if (8'(ptr + WORD_LEN) > flen) begin
            tx_idx <= '0;
            st <= S_TX;
          end else begin
            acc_k <= '0;
            acc_last <= LAST_WORD_BYTE;
            acc_we <= (op == OP_WRITE);
            acc_word <= buf_word;
            ret <= S_POST;
            st <= S_ACC;
          end
        end
        S_POST: begin
          case (op)
            OP_READ, OP_WRITE: begin
              ptr <= ptr + WORD_LEN;
              addr <= addr + 16'(WORD_LEN);
              if (cnt <= 8'h01) st <= S_CMD;
              else begin
                cnt <= cnt - 8'h01;
                st <= S_WORD;
              end
            end
            OP_WAIT0, OP_WAIT1: begin
              if ((acc_word & buf_word) == ((op == OP_WAIT1) ? buf_word : 32'h0)
                  || polls == POLL_LIMIT) begin
                ptr <= ptr + WORD_LEN;
                st <= S_CMD;
              end else begin
                polls <= polls + 8'h01;
                acc_k <= '0;
                st <= S_ACC;
              end
            end
            OP_CLR, OP_SET: begin
              acc_word <= (op == OP_SET) ? (acc_word | buf_word)
                                         : (acc_word & ~buf_word);
              acc_we <= 1'h1;
              acc_k <= '0;
              ret <= S_MODW;
              st <= S_ACC;
            end
            default: st <= S_CMD;
          endcase
        end
        S_MODW: begin
          ptr <= ptr + WORD_LEN;
          st <= S_CMD;
        end
        S_TX: begin
          if (f_in_ready) begin
            if (tx_idx == flen - 8'h01) st <= S_DRAIN;
            else tx_idx <= tx_idx + 8'h01;
          end
        end
        S_DRAIN: begin
          if (!ib_busy) st <= S_IDLE;
        end
      endcase
    end
  end

  assign f_in_valid = (st == S_TX);
  assign f_in_data = {tx_idx == flen - 8'h01, fbuf[7'(swap_idx(tx_idx))]};
  assign f_out_ready = !tx_valid || tx_ready;

  mra_fifo #(.W(9), .D(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // output register stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_valid <= 1'h0;
      tx_data <= '0;
      tx_last <= 1'h0;
      tx_port <= '0;
    end else if (f_out_ready) begin
      tx_valid <= f_out_valid;
      tx_last <= f_out_data[8];
      tx_data <= f_out_data[7:0];
      tx_port <= resp_port;
    end
  end

  a_sel_default: assert property (
    @(posedge clk) disable iff (!rst_b) !sel_touched |-> ib_port == IB_DEFAULT_PORT)
    else $error("port selection left its default");
  a_strap_take: assert property (
    @(posedge clk) disable iff (!rst_b) $rose(strap_done) |-> ib_en == $past(in_band_access_strap))
    else $error("enable differs from strap");
  a_other_port: assert property (
    @(posedge clk) disable iff (!rst_b) rx_valid && !in_frame && rx_port != ib_port |=> !hit)
    else $error("frame on other port recognised");
  a_busy_drop: assert property (
    @(posedge clk) disable iff (!rst_b) rx_valid && rx_last && mgmt_end && ib_busy
      |=> vd_valid && vd_mgmt && vd_drop)
    else $error("busy frame not dropped");
  a_resp_swap: assert property (
    @(posedge clk) disable iff (!rst_b) st == S_TX && tx_idx < MAC_LEN
      |-> f_in_data[7:0] == fbuf[7'(tx_idx + MAC_LEN)])
    else $error("address swap wrong");
  a_smi_map: assert property (
    @(posedge clk) disable iff (!rst_b) smi_go && !smi_rsv_n
      |-> ##2 rb_req && rb_addr == $past(smi_map, 2))
    else $error("standard register mapped wrong");
  a_rsvd_zero: assert property (
    @(posedge clk) disable iff (!rst_b) smi_go && smi_rsv_n |=> smi_ack && smi_rdata == 16'h0000 && !rb_req)
    else $error("reserved register not zero");
  a_word_size: assert property (
    @(posedge clk) disable iff (!rst_b) st == S_POST |-> acc_k == LAST_WORD_BYTE && !acc_smi)
    else $error("transfer shorter than a word");
  a_set_bits: assert property (
    @(posedge clk) disable iff (!rst_b) st == S_POST && op == OP_SET
      |=> acc_we && (acc_word & buf_word) == buf_word)
    else $error("masked bits not set");
endmodule : mra_top
`default_nettype wire

// ==== bench/mra_regmodel.sv ====
`timescale 1ns/1ps
`default_nettype none
module mra_regmodel (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // byte register bus
  input wire logic rb_req,
  input wire logic rb_we,
  input wire logic [15:0] rb_addr,
  input wire logic [7:0] rb_wdata,
  output logic rb_ack,
  output logic [7:0] rb_rdata,
  // extra answer delay in cycles
  input wire logic [3:0] lat
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr;
  logic [7:0] wdata;
  logic we;
  logic busy;
  logic [3:0] cnt;

  // seeded contents: byte at a holds a[7:0] ^ 5a
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'h0;
      rb_ack <= 1'h0;
      rb_rdata <= 8'h00;
      cnt <= 4'h0;
    end else begin
      rb_ack <= 1'h0;
      // no stale data between answers
      rb_rdata <= ~rb_rdata;
      if (rb_req) begin
        busy <= 1'h1;
        cnt <= lat;
        addr <= rb_addr;
        we <= rb_we;
        wdata <= rb_wdata;
      end else if (busy && cnt == 4'h0) begin
        rb_ack <= 1'h1;
        busy <= 1'h0;
        if (we) begin
          mem[addr] <= wdata;
        end else begin
          rb_rdata <= mem[addr];
        end
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : mra_regmodel
`default_nettype wire

// ==== bench/mgmt_register_access_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module mgmt_register_access_tb
  import mra_pkg::*;
;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic strap = 1'h1;
  logic sel_wr = 1'h0;
  logic [2:0] sel_port = 3'h0;
  logic rx_valid = 1'h0;
  logic [2:0] rx_port = 3'h0;
  logic [7:0] rx_data = 8'h00;
  logic rx_last = 1'h0;
  logic tx_ready = 1'h0;
  logic smi_req = 1'h0;
  logic smi_write = 1'h0;
  logic [4:0] smi_phy = 5'h00;
  logic [4:0] smi_reg = 5'h00;
  logic [15:0] smi_wdata = 16'h0000;
  logic [3:0] lat = 4'h0;
  logic ib_en, vd_valid, vd_mgmt, vd_drop, tx_valid, tx_last, smi_ack;
  logic rb_req, rb_we, rb_ack;
  logic [2:0] ib_port, tx_port;
  logic [7:0] tx_data, rb_wdata, rb_rdata;
  logic [15:0] smi_rdata, rb_addr;
  int bad_count = 0;
  int total_checks = 0;
  logic [7:0] fr[$];
  logic [7:0] ex[$];

  always #4 clk = ~clk;

  mra_top u_dut (.clk(clk), .rst_b(rst_b), .in_band_access_strap(strap), .ib_sel_wr(sel_wr),
    .ib_sel_port(sel_port), .ib_en(ib_en), .ib_port(ib_port), .rx_valid(rx_valid),
    .rx_port(rx_port), .rx_data(rx_data), .rx_last(rx_last), .vd_valid(vd_valid),
    .vd_mgmt(vd_mgmt), .vd_drop(vd_drop), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_port(tx_port), .tx_data(tx_data), .tx_last(tx_last), .smi_req(smi_req),
    .smi_write(smi_write), .smi_phy(smi_phy), .smi_reg(smi_reg), .smi_wdata(smi_wdata),
    .smi_ack(smi_ack), .smi_rdata(smi_rdata), .rb_req(rb_req), .rb_we(rb_we),
    .rb_addr(rb_addr), .rb_wdata(rb_wdata), .rb_ack(rb_ack), .rb_rdata(rb_rdata));

  mra_regmodel u_model (.clk(clk), .rst_b(rst_b), .rb_req(rb_req), .rb_we(rb_we),
    .rb_addr(rb_addr), .rb_wdata(rb_wdata), .rb_ack(rb_ack), .rb_rdata(rb_rdata), .lat(lat));

  task end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task hang();
    chk("timeout", 32'h1, 32'h0);
    end_sim();
  endtask : hang

  task do_reset(input logic s);
    @(negedge clk);
    rst_b = 1'h0;
    strap = s;
    repeat (20) @(negedge clk);
    rst_b = 1'h1;
    repeat (2) @(negedge clk);
  endtask : do_reset

  task smi(input logic wr, input logic [4:0] phy, input logic [4:0] r, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    smi_req = 1'h1;
    smi_write = wr;
    smi_phy = phy;
    smi_reg = r;
    smi_wdata = d;
    @(negedge clk);
    smi_req = 1'h0;
    while (smi_ack !== 1'h1) begin
      if (n++ > 60) hang();
      @(negedge clk);
    end
  endtask : smi

  // request in fr, expected echo with addresses swapped in ex
  task frame(input logic [7:0] op, input logic [15:0] a, input logic [7:0] cnt, input int nw,
             input logic [31:0] w);
    fr = {};
    for (int i = 0; i < 6; i++) fr.push_back(SWITCH_MAC[47-8*i -: 8]);
    for (int i = 0; i < 6; i++) fr.push_back(8'h10 + 8'(i));
    repeat (4) fr.push_back(8'h00);
    fr.push_back(MGMT_ETYPE[15:8]);
    fr.push_back(MGMT_ETYPE[7:0]);
    fr.push_back(op);
    fr.push_back(a[15:8]);
    fr.push_back(a[7:0]);
    fr.push_back(cnt);
    for (int j = 0; j < 4 * nw; j++) fr.push_back(w[31-8*(j%4) -: 8]);
    ex = fr;
    for (int i = 0; i < 6; i++) begin
      ex[i] = fr[i+6];
      ex[i+6] = fr[i];
    end
  endtask : frame

  task send(input logic [2:0] port, input logic [1:0] exp_vd);
    int n;
    n = 0;
    foreach (fr[i]) begin
      @(negedge clk);
      rx_valid = 1'h1;
      rx_port = port;
      rx_data = fr[i];
      rx_last = (i == fr.size() - 1);
    end
    @(negedge clk);
    rx_valid = 1'h0;
    rx_last = 1'h0;
    while (vd_valid !== 1'h1) begin
      if (n++ > 4) hang();
      @(negedge clk);
    end
    chk("verdict mgmt,drop", 32'(exp_vd), 32'({vd_mgmt, vd_drop}));
  endtask : send

  task recv(input int ncmp, input logic [2:0] port);
    int n;
    int k;
    n = 0;
    k = 0;
    tx_ready = 1'h1;
    while (k < ex.size()) begin
      if (tx_valid === 1'h1) begin
        if (k < ncmp) chk("tx_data", 32'(ex[k]), 32'(tx_data));
        chk("tx_last", 32'(k == ex.size() - 1), 32'(tx_last));
        chk("tx_port", 32'(port), 32'(tx_port));
        k++;
      end
      if (n++ > 600) hang();
      @(negedge clk);
    end
    tx_ready = 1'h0;
  endtask : recv

  task t_smi();
    smi(1'h1, 5'h02, 5'h01, 16'ha55a);
    chk("byte 2102", 32'ha5, 32'(u_model.mem[16'h2102]));
    chk("byte 2103", 32'h5a, 32'(u_model.mem[16'h2103]));
    lat = 4'h3;
    smi(1'h0, 5'h02, 5'h01, 16'h0000);
    chk("smi_rdata", 32'ha55a, 32'(smi_rdata));
    smi(1'h0, 5'h03, 5'h0d, 16'h0000);
    chk("smi_rdata", 32'h4041, 32'(smi_rdata));
    smi(1'h0, 5'h02, 5'h0b, 16'h0000);
    chk("smi_rdata", 32'h0, 32'(smi_rdata));
    smi(1'h1, 5'h02, 5'h10, 16'hffff);
    chk("byte 2120", 32'h7a, 32'(u_model.mem[16'h2120]));
    smi(1'h0, 5'h05, 5'h1f, 16'h0000);
    chk("smi_rdata", 32'h6465, 32'(smi_rdata));
    smi(1'h0, 5'h06, 5'h01, 16'h0000);
    chk("smi_rdata", 32'h0, 32'(smi_rdata));
  endtask : t_smi

  task t_burst();
    frame(8'h01, 16'h4104, 8'h02, 2, 32'h0);
    for (int i = 0; i < 8; i++) ex[22+i] = (8'h04 + 8'(i)) ^ 8'h5a;
    send(3'h6, 2'h2);
    recv(ex.size(), 3'h6);
  endtask : t_burst

  task t_busy();
    frame(8'h01, 16'h3100, 8'h01, 1, 32'h0);
    for (int i = 0; i < 4; i++) ex[22+i] = 8'(i) ^ 8'h5a;
    send(3'h6, 2'h2);
    send(3'h6, 2'h3);
    recv(ex.size(), 3'h6);
  endtask : t_busy

  task op_run(input logic [7:0] op, input logic [15:0] a, input logic [31:0] w);
    frame(op, a, 8'h01, 1, w);
    send(3'h6, 2'h2);
    recv(12, 3'h6);
  endtask : op_run

  task t_ops();
    op_run(8'h02, 16'h5100, 32'h12345678);
    chk("byte 5100", 32'h12, 32'(u_model.mem[16'h5100]));
    chk("byte 5103", 32'h78, 32'(u_model.mem[16'h5103]));
    op_run(8'h06, 16'h3104, 32'h000000f0);
    chk("byte 3107", 32'hfd, 32'(u_model.mem[16'h3107]));
    chk("byte 3106", 32'h5c, 32'(u_model.mem[16'h3106]));
    op_run(8'h05, 16'h3104, 32'hf0000000);
    chk("byte 3104", 32'h0e, 32'(u_model.mem[16'h3104]));
    chk("byte 3107", 32'hfd, 32'(u_model.mem[16'h3107]));
    op_run(8'h04, 16'h3104, 32'h000000f0);
    op_run(8'h03, 16'h3104, 32'h00000002);
  endtask : t_ops

  task sel(input logic [2:0] p);
    @(negedge clk);
    sel_wr = 1'h1;
    sel_port = p;
    @(negedge clk);
    sel_wr = 1'h0;
  endtask : sel

  task t_port();
    sel(3'h1);
    chk("ib_port", 32'h1, 32'(ib_port));
    sel(3'h7);
    chk("ib_port", 32'h1, 32'(ib_port));
    frame(8'h01, 16'h3100, 8'h01, 1, 32'h0);
    send(3'h6, 2'h0);
    send(3'h1, 2'h2);
    recv(12, 3'h1);
    fr[17] = 8'h00;
    send(3'h1, 2'h0);
  endtask : t_port

  task t_reset(input logic s);
    do_reset(s);
    chk("ib_port", 32'h6, 32'(ib_port));
    chk("ib_en", 32'(s), 32'(ib_en));
  endtask : t_reset

  task t_strap_off();
    frame(8'h01, 16'h3100, 8'h01, 1, 32'h0);
    send(3'h6, 2'h0);
  endtask : t_strap_off

  initial begin
    t_reset(1'h1);
    t_smi();
    t_burst();
    t_busy();
    t_ops();
    t_port();
    t_reset(1'h0);
    t_strap_off();
    end_sim();
  end
endmodule : mgmt_register_access_tb
`default_nettype wire
